// ### core/trip_boundaries.sv
// trip boundary registers, locks and alarm output of the sensor
`timescale 1ns/1ns
module trip_boundaries (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic [15:0] temp_i,
    input  wire logic        temp_valid_i,
    output logic [15:0]      reg_rdata_o,
    output logic             reg_rvalid_o,
    output logic [2:0]       trip_flags_o,
    output logic             event_o,
    output logic             event_oe_o
);
    trip_pkg::trip_state_t    state;
    trip_pkg::trip_state_t    next_state;
    trip_pkg::trip_flags_t    cmp_flags;
    logic [2:0][15:0]         cmp_bound;
    logic [2:0]               cmp_above;
    logic [2:0]               cmp_old;
    logic [2:0]               cmp_new;
    logic [5:0]               hyst;
    logic                     any_lock;
    logic                     wr_cfg;
    logic                     wr_upper;
    logic                     wr_lower;
    logic                     wr_crit;
    logic                     alarm;
    logic                     flag_edge;
    logic [15:0]              cfg_read;

    // comparator inputs: index 2 critical, 1 upper, 0 lower
    assign cmp_bound = {state.critical, state.upper, state.lower};
    assign cmp_above = 3'h6;
    assign cmp_old   = state.flags;
    assign hyst      = trip_pkg::hyst_eighths(state.cfg.hyst_sel);

    // one comparator per boundary, evaluated against temperature 12:1
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_cmp
            trip_compare u_cmp (
                .temp_i      (temp_i[12:1]),
                .bound_i     (cmp_bound[gi]),
                .hyst_i      (hyst),
                .above_i     (cmp_above[gi]),
                .flag_i      (cmp_old[gi]),
                .next_flag_o (cmp_new[gi])
            );
        end
    endgenerate

    assign cmp_flags = cmp_new;

    // write decode; locks keep the boundaries read-only
    assign any_lock = state.cfg.win_lock | state.cfg.crit_lock;
    assign wr_cfg   = reg_wr_i && (reg_addr_i == trip_pkg::ADDR_CONFIG);
    assign wr_upper = reg_wr_i && (reg_addr_i == trip_pkg::ADDR_UPPER)
                      && !state.cfg.win_lock;
    assign wr_lower = reg_wr_i && (reg_addr_i == trip_pkg::ADDR_LOWER)
                      && !state.cfg.win_lock;
    assign wr_crit  = reg_wr_i && (reg_addr_i == trip_pkg::ADDR_CRITICAL)
                      && !state.cfg.crit_lock;

    // readback of the configuration bits held here
    always_comb
    begin
        cfg_read = 16'h0000;
        cfg_read[trip_pkg::CFG_HYST_POS +: 2]     = state.cfg.hyst_sel;
        cfg_read[trip_pkg::CFG_CRIT_LOCK_POS]     = state.cfg.crit_lock;
        cfg_read[trip_pkg::CFG_WIN_LOCK_POS]      = state.cfg.win_lock;
        cfg_read[trip_pkg::CFG_EVT_STS_POS]       = state.event_oe;
        cfg_read[trip_pkg::CFG_OUT_EN_POS]        = state.cfg.out_en;
        cfg_read[trip_pkg::CFG_CRIT_ONLY_POS]     = state.cfg.crit_only;
        cfg_read[trip_pkg::CFG_INT_MODE_POS]      = state.cfg.int_mode;
    end

    // a conversion that sets crit or, outside critical-only mode, changes high or low
    always_comb
    begin
        flag_edge = 1'b0;
        if (temp_valid_i)
        begin
            if (state.cfg.crit_only)
                flag_edge = cmp_flags.crit & ~state.flags.crit;
            else
                flag_edge = (cmp_flags.high != state.flags.high)
                          | (cmp_flags.low != state.flags.low)
                          | (cmp_flags.crit & ~state.flags.crit);
        end
    end

    // next state
    always_comb
    begin
        next_state        = state;
        next_state.rvalid = 1'b0;

        // boundaries keep only sign and threshold bits
        if (wr_upper)
            next_state.upper = trip_pkg::bound_mask(reg_wdata_i);
        if (wr_lower)
            next_state.lower = trip_pkg::bound_mask(reg_wdata_i);
        if (wr_crit)
            next_state.critical =
                trip_pkg::bound_mask(reg_wdata_i);

        // configuration: locks only ever set; out_en and int_mode frozen by either lock, crit_only by win_lock, hyst_sel never
        if (wr_cfg)
        begin
            next_state.cfg.hyst_sel =
                reg_wdata_i[trip_pkg::CFG_HYST_POS +: 2];
            if (reg_wdata_i[trip_pkg::CFG_CRIT_LOCK_POS])
                next_state.cfg.crit_lock = 1'b1;
            if (reg_wdata_i[trip_pkg::CFG_WIN_LOCK_POS])
                next_state.cfg.win_lock = 1'b1;
            if (!any_lock)
            begin
                next_state.cfg.out_en =
                    reg_wdata_i[trip_pkg::CFG_OUT_EN_POS];
                next_state.cfg.int_mode =
                    reg_wdata_i[trip_pkg::CFG_INT_MODE_POS];
            end
            if (!state.cfg.win_lock)
                next_state.cfg.crit_only =
                    reg_wdata_i[trip_pkg::CFG_CRIT_ONLY_POS];
            // event clear only matters in interrupt mode
            if (reg_wdata_i[trip_pkg::CFG_EVT_CLR_POS]
                && state.cfg.int_mode)
                next_state.int_latch = 1'b0;
        end

        // flags move only on a completed conversion
        if (temp_valid_i)
            next_state.flags = cmp_flags;

        // a new event wins over a clear in the same cycle
        if (flag_edge && state.cfg.out_en && state.cfg.int_mode)
            next_state.int_latch = 1'b1;
        if (!state.cfg.int_mode)
            next_state.int_latch = 1'b0;

        // alarm from the flags as they will be after this cycle;
        // kept in this process so no loop runs through next_state
        if (state.cfg.int_mode)
            alarm = next_state.int_latch
                  | next_state.flags.crit;
        else if (state.cfg.crit_only)
            alarm = next_state.flags.crit;
        else
            alarm = next_state.flags.crit | next_state.flags.high
                  | next_state.flags.low;

        // open-drain pin, active low: driven only while enabled
        next_state.event_oe    = state.cfg.out_en & alarm;
        next_state.event_level = 1'b0;

        // reads answer one cycle later, reserved bits stay zero
        if (reg_rd_i)
        begin
            next_state.rvalid = 1'b1;
            case (reg_addr_i)
                trip_pkg::ADDR_CONFIG:   next_state.rdata = cfg_read;
                trip_pkg::ADDR_UPPER:    next_state.rdata = state.upper;
                trip_pkg::ADDR_LOWER:    next_state.rdata = state.lower;
                trip_pkg::ADDR_CRITICAL: next_state.rdata =
                                             state.critical;
                default:                 next_state.rdata = 16'h0000;
            endcase
        end
    end

    // state register; the lock bits fall only with this reset
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            state.upper       <= trip_pkg::BOUND_RESET;
            state.lower       <= trip_pkg::BOUND_RESET;
            state.critical    <= trip_pkg::BOUND_RESET;
            state.cfg         <= trip_pkg::CFG_RESET;
            state.flags       <= '0;
            state.int_latch   <= 1'b0;
            state.rdata       <= 16'h0000;
            state.rvalid      <= 1'b0;
            state.event_oe    <= 1'b0;
            state.event_level <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // outputs straight from the state register
    assign reg_rdata_o  = state.rdata;
    assign reg_rvalid_o = state.rvalid;
    assign trip_flags_o = state.flags;
    assign event_o      = state.event_level;
    assign event_oe_o   = state.event_oe;

endmodule : trip_boundaries

// ### core/trip_compare.sv
// one boundary comparator with hysteresis
`timescale 1ns/1ns
module trip_compare (
    input  wire logic [11:0] temp_i,
    input  wire logic [15:0] bound_i,
    input  wire logic [5:0]  hyst_i,
    input  wire logic        above_i,
    input  wire logic        flag_i,
    output logic             next_flag_o
);
    logic signed [13:0] temp_s;
    logic signed [13:0] bound_s;
    logic signed [13:0] low_edge;

    // both sides in eighths of a degree, sign extended to avoid overflow
    assign temp_s   = {{2{temp_i[11]}}, temp_i};
    assign bound_s  = {{2{bound_i[trip_pkg::BOUND_SIGN_POS]}},
                       bound_i[trip_pkg::BOUND_SIGN_POS:trip_pkg::BOUND_LSB_POS],
                       1'b0};
    assign low_edge = bound_s - $signed({8'h00, hyst_i});

    // over-type trips on strictly above, releases at or below edge
    always_comb
    begin
        next_flag_o = flag_i;
        if (above_i)
        begin
            if (temp_s > bound_s)
                next_flag_o = 1'b1;
            else if (temp_s <= low_edge)
                next_flag_o = 1'b0;
        end
        else
        begin
            if (temp_s < low_edge)
                next_flag_o = 1'b1;
            else if (temp_s >= bound_s)
                next_flag_o = 1'b0;
        end
    end

endmodule : trip_compare

// ### inc/trip_pkg.sv
// constants, field layouts and carrier types of the trip boundary block
package trip_pkg;

    // register addresses on the internal register port
    localparam logic [7:0]  ADDR_CONFIG   = 8'h01;
    localparam logic [7:0]  ADDR_UPPER    = 8'h02;
    localparam logic [7:0]  ADDR_LOWER    = 8'h03;
    localparam logic [7:0]  ADDR_CRITICAL = 8'h04;

    // boundary register layout
    localparam int          BOUND_SIGN_POS = 12;
    localparam int          BOUND_MSB_POS  = 11;
    localparam int          BOUND_LSB_POS  = 2;
    localparam logic [15:0] BOUND_RW_MASK  = 16'h1ffc;
    localparam logic [15:0] BOUND_RESET    = 16'h0000;

    // configuration register layout
    localparam int          CFG_HYST_POS      = 9;
    localparam int          CFG_CRIT_LOCK_POS = 7;
    localparam int          CFG_WIN_LOCK_POS  = 6;
    localparam int          CFG_EVT_CLR_POS   = 5;
    localparam int          CFG_EVT_STS_POS   = 4;
    localparam int          CFG_OUT_EN_POS    = 3;
    localparam int          CFG_CRIT_ONLY_POS = 2;
    localparam int          CFG_INT_MODE_POS  = 0;

    // hysteresis in eighths of a degree: off, 1.5, 3, 6 degrees
    localparam logic [5:0]  HYST_OFF = 6'h00;
    localparam logic [5:0]  HYST_1P5 = 6'h0c;
    localparam logic [5:0]  HYST_3P0 = 6'h18;
    localparam logic [5:0]  HYST_6P0 = 6'h30;

    // configuration bits held by this block
    typedef struct packed {
        logic [1:0] hyst_sel;
        logic       crit_lock;
        logic       win_lock;
        logic       out_en;
        logic       crit_only;
        logic       int_mode;
    } cfg_t;

    localparam cfg_t CFG_RESET = '0;

    // trip flags, order matches temperature bits 15:13
    typedef struct packed {
        logic crit;
        logic high;
        logic low;
    } trip_flags_t;

    // whole state of the top module
    typedef struct packed {
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] critical;
        cfg_t        cfg;
        trip_flags_t flags;
        logic        int_latch;
        logic [15:0] rdata;
        logic        rvalid;
        logic        event_oe;
        logic        event_level;
    } trip_state_t;

    // keep only the writable threshold bits, reserved bits stay zero
    function automatic logic [15:0] bound_mask(input logic [15:0] value);
        bound_mask = value & BOUND_RW_MASK;
    endfunction : bound_mask

    // hysteresis selection to eighths of a degree
    function automatic logic [5:0] hyst_eighths(input logic [1:0] sel);
        case (sel)
            2'h0:    hyst_eighths = HYST_OFF;
            2'h1:    hyst_eighths = HYST_1P5;
            2'h2:    hyst_eighths = HYST_3P0;
            default: hyst_eighths = HYST_6P0;
        endcase
    endfunction : hyst_eighths

endpackage : trip_pkg

// ### testbench/tb.sv
// self-checking bench of the trip boundary block
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic [1:0]  kind;
        logic [7:0]  addr;
        logic [15:0] data;
        logic [15:0] expv;
        logic        oe;
    } row_t;
    localparam logic [1:0] KR = 2'h0; // write, read back
    localparam logic [1:0] KC = 2'h1; // config write only
    localparam logic [1:0] KV = 2'h2; // conversion
    // boundaries 80/20/100 degrees, then hysteresis 1.5 degrees
    localparam row_t ROWS [0:45] = '{
        '{KR, 8'h02, 16'hffff, 16'h1ffc, 1'b0},
        '{KR, 8'h03, 16'he003, 16'h0000, 1'b0},
        '{KR, 8'h04, 16'ha5a7, 16'h05a4, 1'b0},
        '{KR, 8'h10, 16'hffff, 16'h0000, 1'b0},
        '{KR, 8'h02, 16'h0500, 16'h0500, 1'b0},
        '{KR, 8'h03, 16'h0140, 16'h0140, 1'b0},
        '{KR, 8'h04, 16'h0640, 16'h0640, 1'b0},
        '{KC, 8'h01, 16'h0008, 16'h0000, 1'b0},
        '{KV, 8'h00, 16'h0550, 16'h0002, 1'b1},
        '{KV, 8'h00, 16'h0500, 16'h0000, 1'b0},
        '{KC, 8'h01, 16'h0208, 16'h0000, 1'b0},
        '{KV, 8'h00, 16'h0510, 16'h0002, 1'b1},
        '{KV, 8'h00, 16'h04f0, 16'h0002, 1'b1},
        '{KV, 8'h00, 16'h04e8, 16'h0000, 1'b0},
        '{KV, 8'h00, 16'h0138, 16'h0000, 1'b0},
        '{KV, 8'h00, 16'h0120, 16'h0001, 1'b1},
        '{KV, 8'h00, 16'h0130, 16'h0001, 1'b1},
        '{KV, 8'h00, 16'h0140, 16'h0000, 1'b0},
        '{KV, 8'h00, 16'h0650, 16'h0006, 1'b1},
        '{KV, 8'h00, 16'h0630, 16'h0006, 1'b1},
        '{KV, 8'h00, 16'h0628, 16'h0002, 1'b1},
        '{KV, 8'h00, 16'h1fc0, 16'h0001, 1'b1},
        '{KC, 8'h01, 16'h0200, 16'h0000, 1'b0},
        '{KV, 8'h00, 16'h1fc0, 16'h0001, 1'b0},
        // interrupt mode: latch holds until cleared, crit still drives
        '{KR, 8'h01, 16'h0009, 16'h0009, 1'b0},
        '{KV, 8'h00, 16'h0180, 16'h0000, 1'b1},
        '{KV, 8'h00, 16'h0180, 16'h0000, 1'b1},
        '{KR, 8'h01, 16'h0029, 16'h0009, 1'b0},
        '{KV, 8'h00, 16'h0180, 16'h0000, 1'b0},
        '{KV, 8'h00, 16'h0650, 16'h0006, 1'b1},
        '{KR, 8'h01, 16'h0029, 16'h0019, 1'b0},
        '{KV, 8'h00, 16'h0650, 16'h0006, 1'b1},
        // critical only, then hysteresis 6 and 3 degrees
        '{KC, 8'h01, 16'h000c, 16'h0000, 1'b0},
        '{KV, 8'h00, 16'h0180, 16'h0000, 1'b0},
        '{KV, 8'h00, 16'h0550, 16'h0002, 1'b0},
        '{KV, 8'h00, 16'h0650, 16'h0006, 1'b1},
        '{KC, 8'h01, 16'h0608, 16'h0000, 1'b0},
        '{KV, 8'h00, 16'h04b0, 16'h0002, 1'b1},
        '{KV, 8'h00, 16'h04a0, 16'h0000, 1'b0},
        '{KC, 8'h01, 16'h0408, 16'h0000, 1'b0},
        '{KV, 8'h00, 16'h0510, 16'h0002, 1'b1},
        '{KV, 8'h00, 16'h04d0, 16'h0000, 1'b0},
        // lower boundary below zero, sign bit set
        '{KR, 8'h03, 16'h1f80, 16'h1f80, 1'b0},
        '{KV, 8'h00, 16'h1fc0, 16'h0000, 1'b0},
        '{KV, 8'h00, 16'h1f40, 16'h0001, 1'b1},
        '{KR, 8'h03, 16'h0140, 16'h0140, 1'b0}};

    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_wdata;
    logic [15:0] temp_i = 16'h0000;
    logic        temp_valid_i = 1'b0;
    logic [15:0] rdata;
    logic        rvalid;
    logic [2:0]  flags;
    logic        event_o;
    logic        event_oe;
    logic [15:0] d;
    row_t        r;
    int          error_cnt = 0;
    int          compares = 0;

    always #5 clk_i = ~clk_i;

    trip_boundaries u_dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
        .temp_i(temp_i), .temp_valid_i(temp_valid_i), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .trip_flags_o(flags), .event_o(event_o),
        .event_oe_o(event_oe));
    trip_host u_host (
        .clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(reg_addr),
        .wr_o(reg_wr), .rd_o(reg_rd), .wdata_o(reg_wdata));

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // one conversion pulse, sample scrambled once it has been taken
    task automatic conv(input logic [15:0] t);
        @(negedge clk_i);
        temp_i = t;
        temp_valid_i = 1'b1;
        @(negedge clk_i);
        temp_valid_i = 1'b0;
        temp_i = ~t; // comparator must use the taken sample
    endtask : conv

    // reset held 16 cycles, then boundaries, locks and flags read zero
    task automatic reset_check();
        reset_n_i = 1'b0;
        repeat (16) @(negedge clk_i);
        reset_n_i = 1'b1;
        chk("flags", 16'h0000, {13'h0000, flags});
        u_host.rd(trip_pkg::ADDR_CONFIG, d);
        chk("locks", 16'h0000, d & 16'h00c0);
        for (int a = 2; a < 5; a++)
        begin
            u_host.rd(8'(a), d);
            chk("boundary", 16'h0000, d);
        end
    endtask : reset_check

    task automatic end_of_test();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    // watchdog far beyond the fewer than two hundred cycles the tests need
    initial
    begin
        #100000;
        error_cnt++;
        end_of_test();
    end

    initial
    begin
        reset_check();
        foreach (ROWS[i])
        begin
            r = ROWS[i];
            if (r.kind == KV)
            begin
                conv(r.data);
                chk("flags", r.expv, {13'h0000, flags});
                chk("alarm", 16'(r.oe), 16'(event_oe));
                chk("pin", 16'h0000, 16'(event_o));
            end
            else
            begin
                u_host.wr(r.addr, r.data);
                if (r.kind == KR)
                begin
                    u_host.rd(r.addr, d);
                    chk("readback", r.expv, d);
                end
            end
        end
        // window lock: upper and lower frozen, critical still open
        u_host.wr(trip_pkg::ADDR_CONFIG, 16'h0040);
        u_host.wr(trip_pkg::ADDR_UPPER, 16'h0000);
        u_host.wr(trip_pkg::ADDR_LOWER, 16'h0000);
        u_host.wr(trip_pkg::ADDR_CRITICAL, 16'h0700);
        u_host.rd(trip_pkg::ADDR_UPPER, d);
        chk("upper", 16'h0500, d);
        u_host.rd(trip_pkg::ADDR_LOWER, d);
        chk("lower", 16'h0140, d);
        u_host.rd(trip_pkg::ADDR_CRITICAL, d);
        chk("critical", 16'h0700, d);
        // critical lock, then an attempt to clear both locks
        u_host.wr(trip_pkg::ADDR_CONFIG, 16'h0080);
        u_host.wr(trip_pkg::ADDR_CRITICAL, 16'h0000);
        u_host.rd(trip_pkg::ADDR_CRITICAL, d);
        chk("critical", 16'h0700, d);
        u_host.wr(trip_pkg::ADDR_CONFIG, 16'h0000);
        u_host.rd(trip_pkg::ADDR_CONFIG, d);
        chk("locks", 16'h00c0, d & 16'h00c0);
        reset_check();
        end_of_test();
    end
endmodule : tb

// ### testbench/trip_boundaries_sva.sv
// port assertions of the trip boundary block
`timescale 1ns/1ns
module trip_boundaries_sva (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] temp_i,
    input wire logic        temp_valid_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        reg_rvalid_o,
    input wire logic [2:0]  trip_flags_o,
    input wire logic        event_o,
    input wire logic        event_oe_o
);
    logic win_sh;
    logic crit_sh;
    logic en_sh;

    // shadow of locks and enable; enable frozen once any lock is held
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            {win_sh, crit_sh, en_sh} <= 3'h0;
        end
        else if (reg_wr_i && reg_addr_i == trip_pkg::ADDR_CONFIG)
        begin
            win_sh <= win_sh | reg_wdata_i[trip_pkg::CFG_WIN_LOCK_POS];
            crit_sh <= crit_sh | reg_wdata_i[trip_pkg::CFG_CRIT_LOCK_POS];
            if (!(win_sh || crit_sh))
            begin
                en_sh <= reg_wdata_i[trip_pkg::CFG_OUT_EN_POS];
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read got no answer");
    a_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("answer without a read");
    a_reserved_zero: assert property (
        reg_rvalid_o && $past(reg_addr_i) inside {[8'h02:8'h04]}
        |-> reg_rdata_o[15:13] == 3'h0 && reg_rdata_o[1:0] == 2'h0)
        else $error("reserved boundary bits not zero");
    a_flags_hold: assert property (
        !temp_valid_i |=> $stable(trip_flags_o))
        else $error("flags moved without a conversion");
    a_oe_needs_en: assert property (
        event_oe_o |-> en_sh || $past(en_sh))
        else $error("alarm driven while output disabled");
    a_crit_drives: assert property (
        trip_flags_o[2] && en_sh && $past(en_sh) |-> event_oe_o)
        else $error("critical flag without alarm");
    a_lock_sticky: assert property (
        reg_rvalid_o && $past(reg_addr_i) == trip_pkg::ADDR_CONFIG
        |-> reg_rdata_o[7:6] == {$past(crit_sh), $past(win_sh)})
        else $error("lock bits read wrong");
    a_pin_level: assert property (event_o == 1'b0)
        else $error("alarm pin value not low");
endmodule : trip_boundaries_sva

bind trip_boundaries trip_boundaries_sva u_sva (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .temp_i(temp_i), .temp_valid_i(temp_valid_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .trip_flags_o(trip_flags_o), .event_o(event_o), .event_oe_o(event_oe_o)
);

// ### testbench/trip_host.sv
// host controller model driving the register port
`timescale 1ns/1ns
module trip_host (
    input  wire logic        clk_i,
    input  wire logic [15:0] rdata_i,
    input  wire logic        rvalid_i,
    output logic      [7:0]  addr_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic      [15:0] wdata_o
);
    initial
    begin
        {addr_o, wr_o, rd_o, wdata_o} = '0;
    end

    // one-cycle write strobe launched off the falling edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~d; // stale data must not look valid
    endtask : wr

    // read strobe, answer taken the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        d = rvalid_i ? rdata_i : 16'hdead; // missing answer never matches
    endtask : rd
endmodule : trip_host
